// ===== rtl/dcc_chan_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dcc_chan_if;
   // Settings and strobes from the register file, and the counter overflow.
   logic enable;
   logic rise_ie;
   logic fall_ie;
   logic flag_wr;
   logic rise_wd;
   logic fall_wd;
   logic overflow;
   // State reported by the channel.
   logic sync_out;
   logic rise_flag;
   logic fall_flag;
   logic latched_out;
   logic irq;

   modport regs (output enable, rise_ie, fall_ie, flag_wr, rise_wd,
      fall_wd, overflow, input sync_out, rise_flag, fall_flag,
      latched_out, irq);
   modport chan (input enable, rise_ie, fall_ie, flag_wr, rise_wd,
      fall_wd, overflow, output sync_out, rise_flag, fall_flag,
      latched_out, irq);
endinterface
`default_nettype wire

// ===== rtl/dcc_channel.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_channel (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Raw comparator decision from the analog core.
   input wire logic raw_in,
   // Register side.
   dcc_chan_if.chan bus
);

   logic sync1_r;
   logic sync2_r;
   logic out_r;
   logic prev_r;
   logic rise_r;
   logic rise_nxt;
   logic fall_r;
   logic fall_nxt;
   logic lout_r;
   logic lout_nxt;
   logic rise_evt;
   logic fall_evt;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
      end
   end

   // Edges are taken from the synchronized, enable-gated value.
   // enabling may flag edges.
   // Turning a comparator on or off can raise a flag on its own, so
   // software clears both flags after any enable or mode change.
   assign rise_evt = out_r & ~prev_r;
   assign fall_evt = ~out_r & prev_r;

   // set wins over a software clear in the same cycle.
   assign rise_nxt = rise_evt | (bus.flag_wr ? bus.rise_wd : rise_r);
   assign fall_nxt = fall_evt | (bus.flag_wr ? bus.fall_wd : fall_r);

   assign lout_nxt = bus.overflow ? out_r : lout_r;

   // Output, history, flags and overflow sample.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_r <= 1'b0;
         prev_r <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
         lout_r <= 1'b0;
      end else begin
         out_r <= sync2_r & bus.enable;
         prev_r <= out_r;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
         lout_r <= lout_nxt;
      end
   end

   assign bus.sync_out = out_r;
   assign bus.rise_flag = rise_r;
   assign bus.fall_flag = fall_r;
   assign bus.latched_out = lout_r;
   assign bus.irq = (rise_r & bus.rise_ie) | (fall_r & bus.fall_ie);

endmodule
`default_nettype wire

// ===== rtl/dcc_pkg.sv
`default_nettype none
package dcc_pkg;

   // Bus and structure widths.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NUM_CMP = 2;
   localparam int NUM_EXT = 8;
   localparam int ROUTE_W = 9;

   // Register offsets; each comparator owns three consecutive addresses.
   localparam logic [3:0] CMP_STRIDE = 4'h3;
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] MODE_OFS = 4'h1;
   localparam logic [3:0] MUX_OFS = 4'h2;

   // Control register fields.
   localparam int EN_BIT = 7;
   localparam int OUT_BIT = 6;
   localparam int RIF_BIT = 5;
   localparam int FIF_BIT = 4;
   localparam int HYP_LSB = 2;
   localparam int HYN_LSB = 0;

   // Mode register fields.
   localparam int LOUT_BIT = 7;
   localparam int RIE_BIT = 5;
   localparam int FIE_BIT = 4;
   localparam int MD_LSB = 0;

   // Input multiplexer register fields.
   localparam int MXN_LSB = 4;
   localparam int MXP_LSB = 0;

   // Reset values.
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h02;
   localparam logic [7:0] MUX_RST = 8'hff;

   // Selection code of the internal source: regulator on the plus side,
   // ground on the minus side.  Codes above it leave the input open.
   localparam logic [3:0] SEL_INTERNAL = 4'h8;

   // Hysteresis amount, one field per polarity.
   typedef enum logic [1:0] {
      DCC_HYST_OFF  = 2'b00,
      DCC_HYST_5MV  = 2'b01,
      DCC_HYST_10MV = 2'b10,
      DCC_HYST_20MV = 2'b11
   } dcc_hyst_e;

   // Response mode: speed against supply current.
   typedef enum logic [1:0] {
      DCC_RESP_FASTEST = 2'b00,
      DCC_RESP_MODE1   = 2'b01,
      DCC_RESP_MODE2   = 2'b10,
      DCC_RESP_SLOWEST = 2'b11
   } dcc_resp_e;

endpackage
`default_nettype wire

// ===== rtl/dcc_top.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dcc_top #(
   parameter int NUM_CMP = dcc_pkg::NUM_CMP
) (
   // Clock and asynchronous reset.
   input wire logic clk,
   input wire logic reset,

   // Register port.
   input wire logic [dcc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dcc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [dcc_pkg::DATA_W-1:0] reg_rdata,

   // Analog comparator cores.
   input wire logic [NUM_CMP-1:0] cmp_raw_in,
   output logic [NUM_CMP-1:0] cmp_power_en,
   output logic [NUM_CMP-1:0][dcc_pkg::ROUTE_W-1:0] pos_route,
   output logic [NUM_CMP-1:0][dcc_pkg::ROUTE_W-1:0] neg_route,
   output logic [NUM_CMP-1:0][1:0] pos_hysteresis_sel,
   output logic [NUM_CMP-1:0][1:0] neg_hysteresis_sel,
   output logic [NUM_CMP-1:0][1:0] response_mode_sel,

   // Port routing fabric.
   output logic [NUM_CMP-1:0] raw_async_output,
   output logic [NUM_CMP-1:0] sync_latched_output,

   // Counter array.
   input wire logic counter_overflow,
   output logic counter_shutdown,

   // System reset and interrupt.
   output logic reset_source,
   output logic [NUM_CMP-1:0] cmp_irq
);

   // Settings held per comparator.
   logic [NUM_CMP-1:0] enable_r;
   logic [NUM_CMP-1:0] rise_ie_r;
   logic [NUM_CMP-1:0] fall_ie_r;
   logic [NUM_CMP-1:0][1:0] hyp_r;
   logic [NUM_CMP-1:0][1:0] hyn_r;
   logic [NUM_CMP-1:0][1:0] mode_r;
   logic [NUM_CMP-1:0][3:0] pos_sel_r;
   logic [NUM_CMP-1:0][3:0] neg_sel_r;

   // Decoded accesses per comparator.
   logic [NUM_CMP-1:0] ctrl_hit;
   logic [NUM_CMP-1:0] mode_hit;
   logic [NUM_CMP-1:0] mux_hit;
   logic [NUM_CMP-1:0] ctrl_wr;
   logic [NUM_CMP-1:0] mode_wr;
   logic [NUM_CMP-1:0] mux_wr;

   // Read words per comparator.
   logic [NUM_CMP-1:0][dcc_pkg::DATA_W-1:0] ctrl_word;
   logic [NUM_CMP-1:0][dcc_pkg::DATA_W-1:0] mode_word;
   logic [NUM_CMP-1:0][dcc_pkg::DATA_W-1:0] mux_word;

   // Channel state seen by the register file.
   logic [NUM_CMP-1:0] sync_out;
   logic [NUM_CMP-1:0] rise_flag;
   logic [NUM_CMP-1:0] fall_flag;
   logic [NUM_CMP-1:0] latched_out;
   logic [NUM_CMP-1:0] chan_irq;

   // Read path.
   logic [dcc_pkg::DATA_W-1:0] rd_mux;
   logic [dcc_pkg::DATA_W-1:0] rdata_r;
   logic [dcc_pkg::DATA_W-1:0] rdata_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
         localparam logic [3:0] BASE = 4'(gi) * dcc_pkg::CMP_STRIDE;

         dcc_chan_if ch_if ();

         // Address decode for this comparator's three registers.
         assign ctrl_hit[gi] = (reg_addr == BASE + dcc_pkg::CTRL_OFS);
         assign mode_hit[gi] = (reg_addr == BASE + dcc_pkg::MODE_OFS);
         assign mux_hit[gi] = (reg_addr == BASE + dcc_pkg::MUX_OFS);
         assign ctrl_wr[gi] = reg_wr & ctrl_hit[gi];
         assign mode_wr[gi] = reg_wr & mode_hit[gi];
         assign mux_wr[gi] = reg_wr & mux_hit[gi];

         // enable and the rest of the control settings.
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               enable_r[gi] <= dcc_pkg::CTRL_RST[dcc_pkg::EN_BIT];
               hyp_r[gi] <= dcc_pkg::CTRL_RST[dcc_pkg::HYP_LSB +: 2];
               hyn_r[gi] <= dcc_pkg::CTRL_RST[dcc_pkg::HYN_LSB +: 2];
            end else if (ctrl_wr[gi]) begin
               enable_r[gi] <= reg_wdata[dcc_pkg::EN_BIT];
               hyp_r[gi] <= reg_wdata[dcc_pkg::HYP_LSB +: 2];
               hyn_r[gi] <= reg_wdata[dcc_pkg::HYN_LSB +: 2];
            end
         end

         // interrupt enables and the response-time setting.
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               rise_ie_r[gi] <= dcc_pkg::MODE_RST[dcc_pkg::RIE_BIT];
               fall_ie_r[gi] <= dcc_pkg::MODE_RST[dcc_pkg::FIE_BIT];
               mode_r[gi] <= dcc_pkg::MODE_RST[dcc_pkg::MD_LSB +: 2];
            end else if (mode_wr[gi]) begin
               rise_ie_r[gi] <= reg_wdata[dcc_pkg::RIE_BIT];
               fall_ie_r[gi] <= reg_wdata[dcc_pkg::FIE_BIT];
               mode_r[gi] <= reg_wdata[dcc_pkg::MD_LSB +: 2];
            end
         end

         // Input multiplexer selections, both open after reset.
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               pos_sel_r[gi] <= dcc_pkg::MUX_RST[dcc_pkg::MXP_LSB +: 4];
               neg_sel_r[gi] <= dcc_pkg::MUX_RST[dcc_pkg::MXN_LSB +: 4];
            end else if (mux_wr[gi]) begin
               pos_sel_r[gi] <= reg_wdata[dcc_pkg::MXP_LSB +: 4];
               neg_sel_r[gi] <= reg_wdata[dcc_pkg::MXN_LSB +: 4];
            end
         end

         // Strobes and settings for the channel; a control write carries
         // the flag values, so writing 0 clears and writing 1 sets.
         // software clear path.
         assign ch_if.enable = enable_r[gi];
         assign ch_if.rise_ie = rise_ie_r[gi];
         assign ch_if.fall_ie = fall_ie_r[gi];
         assign ch_if.flag_wr = ctrl_wr[gi];
         assign ch_if.rise_wd = reg_wdata[dcc_pkg::RIF_BIT];
         assign ch_if.fall_wd = reg_wdata[dcc_pkg::FIF_BIT];
         assign ch_if.overflow = counter_overflow;
         assign sync_out[gi] = ch_if.sync_out;
         assign rise_flag[gi] = ch_if.rise_flag;
         assign fall_flag[gi] = ch_if.fall_flag;
         assign latched_out[gi] = ch_if.latched_out;
         assign chan_irq[gi] = ch_if.irq;

         // synchronizer, edge flags and overflow sample per channel.
         dcc_channel u_chan (
            .clk(clk),
            .reset(reset),
            .raw_in(cmp_raw_in[gi]),
            .bus(ch_if.chan)
         );

         // plus input: one-hot pin channels, then the regulator bit.
         assign pos_route[gi] = (pos_sel_r[gi] <= dcc_pkg::SEL_INTERNAL) ?
            (9'h001 << pos_sel_r[gi]) : 9'h000;
         // minus input: one-hot pin channels, then the ground bit.
         assign neg_route[gi] = (neg_sel_r[gi] <= dcc_pkg::SEL_INTERNAL) ?
            (9'h001 << neg_sel_r[gi]) : 9'h000;

         // hysteresis codes pass straight to the core.
         assign pos_hysteresis_sel[gi] = hyp_r[gi];
         assign neg_hysteresis_sel[gi] = hyn_r[gi];
         // response code passes straight to the core.
         assign response_mode_sel[gi] = mode_r[gi];
         // core power follows the enable bit.
         assign cmp_power_en[gi] = enable_r[gi];

         // raw output is plain gating, so it works with no clock.
         assign raw_async_output[gi] = cmp_raw_in[gi] & enable_r[gi];
         // both output kinds go to the routing fabric.
         assign sync_latched_output[gi] = sync_out[gi];
         assign cmp_irq[gi] = chan_irq[gi];

         // control word carries the live output state.
         assign ctrl_word[gi] = {enable_r[gi], sync_out[gi], rise_flag[gi],
            fall_flag[gi], hyp_r[gi], hyn_r[gi]};
         // Mode word; unused bits read as zero.
         assign mode_word[gi] = {latched_out[gi], 1'b0, rise_ie_r[gi],
            fall_ie_r[gi], 2'b00, mode_r[gi]};
         assign mux_word[gi] = {neg_sel_r[gi], pos_sel_r[gi]};
      end
   endgenerate

   // the first comparator also feeds reset and counter shutdown.
   // The reset path uses the raw output so it still acts in stop mode.
   assign reset_source = raw_async_output[0];
   assign counter_shutdown = sync_latched_output[0];

   // Read selection; an unmapped address returns zero.
   always_comb begin
      rd_mux = '0;
      for (int i = 0; i < NUM_CMP; i++) begin
         if (ctrl_hit[i]) begin
            rd_mux = rd_mux | ctrl_word[i];
         end
         if (mode_hit[i]) begin
            rd_mux = rd_mux | mode_word[i];
         end
         if (mux_hit[i]) begin
            rd_mux = rd_mux | mux_word[i];
         end
      end
   end

   // Data stand only in the cycle after the read strobe.
   assign rdata_nxt = reg_rd ? rd_mux : '0;

   // Read data register; reads have no side effects.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

endmodule
`default_nettype wire

// ===== sim/dcc_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
// Behavioural stand-in for the two analog comparator cores.
module dcc_analog_model (
   // Core power from the block.
   input wire logic [1:0] power_en,
   // Sign of the input difference, set by the bench.
   input wire logic [1:0] level,
   // Raw decision back to the block.
   output logic [1:0] raw
);
   // An unpowered core gives no valid decision, so it shows the opposite
   // level; the block must hold its own outputs low regardless.
   // powered decision
   assign raw = (level & power_en) | (~level & ~power_en);
endmodule
`default_nettype wire

// ===== sim/dcc_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port checker for the comparator block, mostly on comparator 0.
module dcc_top_asserts #(
   parameter int NUM_CMP = 2
) (
   // Clock, reset and register port.
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Core and fabric side.
   input wire logic [NUM_CMP-1:0] cmp_raw_in,
   input wire logic [NUM_CMP-1:0] cmp_power_en,
   input wire logic [NUM_CMP-1:0][8:0] pos_route,
   input wire logic [NUM_CMP-1:0][8:0] neg_route,
   input wire logic [NUM_CMP-1:0][1:0] pos_hysteresis_sel,
   input wire logic [NUM_CMP-1:0][1:0] neg_hysteresis_sel,
   input wire logic [NUM_CMP-1:0] raw_async_output,
   input wire logic [NUM_CMP-1:0] sync_latched_output,
   input wire logic counter_shutdown,
   input wire logic reset_source,
   input wire logic [NUM_CMP-1:0] cmp_irq
);
   // Expected one-hot route; codes above the internal source stay open.
   function automatic logic [8:0] route_of(input logic [3:0] c);
      route_of = (c <= 4'h8) ? 9'h001 << c : 9'h000;
   endfunction

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   chk_raw_gated: assert property (
      raw_async_output == (cmp_raw_in & cmp_power_en))
      else $error("raw output not gated");
   chk_sync_off: assert property (
      (sync_latched_output & ~cmp_power_en & ~$past(cmp_power_en)) == '0)
      else $error("sync output high while off");
   chk_sync_delay: assert property (
      cmp_power_en[0] [*4] |->
      sync_latched_output[0] == $past(cmp_raw_in[0], 3))
      else $error("sync output latency wrong");
   chk_ctrl_write: assert property (
      $past(reg_wr) && $past(reg_addr) == 4'h0 |->
      cmp_power_en[0] == $past(reg_wdata[7]) &&
      pos_hysteresis_sel[0] == $past(reg_wdata[3:2]) &&
      neg_hysteresis_sel[0] == $past(reg_wdata[1:0]))
      else $error("control write not applied");
   chk_route_decode: assert property (
      $past(reg_wr) && $past(reg_addr) == 4'h2 |->
      pos_route[0] == route_of($past(reg_wdata[3:0])) &&
      neg_route[0] == route_of($past(reg_wdata[7:4])))
      else $error("route decode wrong");
   chk_irq_hold: assert property (
      $fell(cmp_irq[0]) |-> $past(reg_wr))
      else $error("interrupt dropped without a write");
   chk_irq_cause: assert property (
      $rose(cmp_irq[0]) |-> $past(reg_wr) ||
      $past(sync_latched_output[0]) != $past(sync_latched_output[0], 2))
      else $error("interrupt without edge or write");
   chk_read_idle: assert property (
      $past(!reg_rd || reg_addr > 4'h5) |-> reg_rdata == 8'h00)
      else $error("read data outside a read slot");
   chk_fabric_taps: assert property (
      counter_shutdown == sync_latched_output[0] &&
      reset_source == raw_async_output[0])
      else $error("fabric taps wrong");

   // Main scenarios reached.
   cover property ($rose(cmp_irq[0]));
   cover property ($fell(cmp_irq[0]));
   cover property (reg_rd && reg_addr > 4'h5);
endmodule
`default_nettype wire

// ===== sim/dcc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
// Bench for the comparator block, judged at its ports.
module dcc_top_tb;
   logic clk, clk_run, reset, reg_wr, reg_rd, counter_overflow;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [1:0] level, cmp_raw_in, cmp_power_en, raw_async_output;
   logic [1:0] sync_latched_output, cmp_irq;
   logic [1:0][8:0] pos_route, neg_route;
   logic [1:0][1:0] pos_hysteresis_sel, neg_hysteresis_sel;
   logic [1:0][1:0] response_mode_sel;
   logic counter_shutdown, reset_source;
   int miscompares, checks;

   dcc_top uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .cmp_raw_in, .cmp_power_en, .pos_route, .neg_route,
      .pos_hysteresis_sel, .neg_hysteresis_sel, .response_mode_sel,
      .raw_async_output, .sync_latched_output, .counter_overflow,
      .counter_shutdown, .reset_source, .cmp_irq);
   dcc_analog_model core (.power_en(cmp_power_en), .level, .raw(cmp_raw_in));

   // Clock; it can be held still to show the raw path needs none.
   initial begin
      clk = 1'b0;
      forever #2 clk = clk_run ? ~clk : clk;
   end

   task automatic chk(input string name, input logic [8:0] exp, got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Bus cycles end just after the edge that took them.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("read data", 9'(e), 9'(reg_rdata));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Reset values of both register sets and the refused addresses.
   task automatic t_reset();
      for (int n = 0; n < 2; n++) begin
         rd(4'(3 * n), 8'h00);
         rd(4'(3 * n + 1), 8'h02);
         rd(4'(3 * n + 2), 8'hff);
      end
      chk("mode sel", 9'h002, 9'(response_mode_sel[1]));
      chk("route", 9'h000, pos_route[0] | neg_route[1]);
      for (int a = 6; a < 16; a++) begin
         wr(4'(a), 8'hff);
         rd(4'(a), 8'h00);
      end
   endtask

   // Every select code, the two sides walking in opposite directions.
   task automatic t_mux();
      logic [8:0] e;
      for (int c = 0; c < 16; c++) begin
         wr(4'h2, {4'(15 - c), 4'(c)});
         e = (c < 9) ? 9'h001 << c : 9'h000;
         chk("plus route", e, pos_route[0]);
         e = (c > 6) ? 9'h001 << (15 - c) : 9'h000;
         chk("minus route", e, neg_route[0]);
      end
      rd(4'h2, 8'h0f);
      wr(4'h5, 8'h38);
      chk("second plus", 9'h100, pos_route[1]);
      chk("second minus", 9'h008, neg_route[1]);
   endtask

   // All hysteresis and response codes on the second comparator.
   task automatic t_fields();
      for (int v = 0; v < 4; v++) begin
         wr(4'h3, {4'h0, 2'(v), 2'(3 - v)});
         chk("plus hyst", 9'(v), 9'(pos_hysteresis_sel[1]));
         chk("minus hyst", 9'(3 - v), 9'(neg_hysteresis_sel[1]));
         wr(4'h4, 8'(v));
         chk("resp mode", 9'(v), 9'(response_mode_sel[1]));
         rd(4'h4, 8'(v));
      end
   endtask

   // Edge flags, their stickiness, clearing and masking.
   task automatic t_edges();
      wr(4'h0, 8'h80);
      cyc(5);
      wr(4'h0, 8'h80);
      wr(4'h1, 8'h32);
      chk("irq idle", 9'h000, 9'(cmp_irq[0]));
      level[0] = 1'b1;
      cyc(2);
      chk("sync early", 9'h000, 9'(sync_latched_output[0]));
      cyc(1);
      chk("sync", 9'h001, 9'(sync_latched_output[0]));
      chk("shutdown", 9'h001, 9'(counter_shutdown));
      chk("reset src", 9'h001, 9'(reset_source));
      cyc(1);
      chk("irq rise", 9'h001, 9'(cmp_irq[0]));
      cyc(20);
      rd(4'h0, 8'he0);
      level[0] = 1'b0;
      cyc(6);
      rd(4'h0, 8'hb0);
      wr(4'h0, 8'h80);
      rd(4'h0, 8'h80);
      chk("irq clear", 9'h000, 9'(cmp_irq[0]));
      wr(4'h1, 8'h12);
      level[0] = 1'b1;
      cyc(6);
      chk("irq masked", 9'h000, 9'(cmp_irq[0]));
      level[0] = 1'b0;
      cyc(6);
      chk("irq fall", 9'h001, 9'(cmp_irq[0]));
      wr(4'h1, 8'h22);
      chk("irq rise only", 9'h001, 9'(cmp_irq[0]));
      wr(4'h1, 8'h02);
      chk("irq none", 9'h000, 9'(cmp_irq[0]));
      wr(4'h0, 8'h80);
   endtask

   // Output captured at a counter overflow and held until the next one.
   task automatic overflow();
      @(posedge clk);
      counter_overflow <= 1'b1;
      @(posedge clk);
      counter_overflow <= 1'b0;
   endtask
   task automatic t_latch();
      level[0] = 1'b1;
      cyc(5);
      overflow();
      rd(4'h1, 8'h82);
      level[0] = 1'b0;
      cyc(5);
      rd(4'h1, 8'h82);
      overflow();
      rd(4'h1, 8'h02);
   endtask

   // Disable forces outputs low; the raw path works with the clock stopped.
   task automatic t_off();
      wr(4'h3, 8'h80);
      level = 2'b11;
      cyc(5);
      wr(4'h0, 8'h00);
      chk("raw off", 9'h002, 9'(raw_async_output));
      chk("power", 9'h002, 9'(cmp_power_en));
      cyc(2);
      chk("sync off", 9'h002, 9'(sync_latched_output));
      clk_run = 1'b0;
      #20 level[1] = 1'b0;
      #1 chk("raw no clock", 9'h000, 9'(raw_async_output[1]));
      level[1] = 1'b1;
      #1 chk("raw no clock", 9'h001, 9'(raw_async_output[1]));
      clk_run = 1'b1;
      wr(4'h4, 8'h12);
      chk("second irq off", 9'h000, 9'(cmp_irq[1]));
      level[1] = 1'b0;
      cyc(6);
      chk("second irq", 9'h001, 9'(cmp_irq[1]));
   endtask

   task automatic end_of_test();
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence.
   initial begin
      clk_run = 1'b1;
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      counter_overflow = 1'b0;
      level = 2'b00;
      miscompares = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_mux();
      t_fields();
      t_edges();
      t_latch();
      t_off();
      end_of_test();
   end

   // Hang guard.
   initial begin
      #100000;
      miscompares++;
      end_of_test();
   end
endmodule

bind dcc_top dcc_top_asserts #(.NUM_CMP(NUM_CMP)) chk_i (.clk, .reset,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_raw_in,
   .cmp_power_en, .pos_route, .neg_route, .pos_hysteresis_sel,
   .neg_hysteresis_sel, .raw_async_output, .sync_latched_output,
   .counter_shutdown, .reset_source, .cmp_irq);
`default_nettype wire
